// ---- hdl/prc_pkg.sv ----
// shared constants and code mapping for the regulator control register bank
package prc_pkg;

  // register addresses
  localparam logic [4:0] ADDR_REG3_VOLT = 5'h00;
  localparam logic [4:0] ADDR_REG1_VOLT = 5'h07;
  localparam logic [4:0] ADDR_REG2_VOLT = 5'h08;
  localparam logic [4:0] ADDR_REG3_SLEEP = 5'h09;
  localparam logic [4:0] ADDR_REG_CTRL = 5'h0a;
  localparam logic [4:0] ADDR_LIN_CTRL = 5'h0b;
  localparam logic [4:0] ADDR_STATUS = 5'h0d;
  localparam logic [4:0] ADDR_MISC_CTRL = 5'h0e;

  // reset values
  localparam logic [6:0] RST_REG3_VOLT = 7'h7f;
  localparam logic [5:0] RST_REG12_VOLT = 6'h12;
  localparam logic [6:0] RST_REG3_SLEEP = 7'h7f;
  localparam logic [7:0] RST_REG_CTRL = 8'h83;
  localparam logic RST_LIN_ON = 1'b1;
  localparam logic RST_OSC_OFF = 1'b0;

  // field positions
  localparam int CTRL_REG3_ON = 7;
  localparam int CTRL_PWM1 = 4;
  localparam int CTRL_PWM2 = 3;
  localparam int CTRL_PWM3 = 2;
  localparam int CTRL_REG1_ON = 1;
  localparam int CTRL_REG2_ON = 0;
  localparam int LIN_ON = 0;
  localparam int MISC_OSC_OFF = 1;
  localparam int ST_LIN_GOOD = 4;
  localparam int ST_REG3_GOOD = 3;
  localparam int ST_REG2_GOOD = 2;
  localparam int ST_REG1_GOOD = 1;
  localparam int ST_POWER_GOOD = 0;

  // serial frame: start bit, read flag, 5 address bits, 8 data bits
  localparam logic [3:0] FRAME_LAST = 4'he;
  localparam logic [3:0] HDR_LAST = 4'h6;

  // voltage mapping in millivolts
  localparam logic [11:0] R12_BASE_MV = 12'd900;
  localparam logic [11:0] R12_STEP_MV = 12'd50;
  localparam logic [5:0] R12_TOP_CODE = 6'h32;
  localparam logic [11:0] R12_MAX_MV = 12'd3400;
  localparam logic [11:0] R3_BASE_MV = 12'd865;
  localparam logic [11:0] R3_STEP_MV = 12'd5;

  function automatic logic [11:0] prc_r12_mv(input logic [5:0] code);
    logic [11:0] mv;
    mv = R12_BASE_MV + R12_STEP_MV * {6'h00, code};
    if (code >= R12_TOP_CODE) begin
      mv = R12_MAX_MV;
    end
    return mv;
  endfunction

  function automatic logic [11:0] prc_r3_mv(input logic [6:0] code);
    return R3_BASE_MV + R3_STEP_MV * {5'h00, code};
  endfunction

endpackage

// ---- hdl/prc_regs.sv ----
// regulator control register bank with its serial register port
// How it works
// RULE_01 - control bit 4 set forces regulator one into PWM mode
// RULE_02 - control bit 3 set forces regulator two into PWM; resets to zero
// RULE_03 - control bit 2 set forces regulator three into PWM; resets to zero
// RULE_04 - control bit 1 enables regulator one; resets to one
// RULE_05 - control bit 0 enables regulator two; resets to one
// RULE_06 - status bit 4 shows linear regulator above ninety percent; status ignores writes
// RULE_07 - status bit 3 shows regulator three above ninety percent
// RULE_08 - status bit 2 shows regulator two above ninety percent
// RULE_09 - status bit 1 shows regulator one above ninety percent
// RULE_10 - codes for regulators one and two: 0.9 V plus 50 mV steps, 3.4 V cap
// RULE_11 - sleep voltage register holds seven-bit regulator three code, resets to 0x7f
// RULE_12 - regulator three code: 0.865 V plus 5 mV steps up to 1.5 V
// RULE_13 - power good held low while regulator three is disabled
// RULE_14 - sleep entry ends by stopping the oscillator through misc bit 1
// RULE_15 - linear regulator enable bit switches it on or off; resets to on
// RULE_16 - control bit 7 enables regulator three; resets to one
// RULE_17 - status bit 0 mirrors power good pin; reserved bits read zero
`timescale 1ns/100ps
module prc_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // serial register port
  input wire logic spi_cs_n_i,
  input wire logic spi_clk_i,
  input wire logic spi_di_i,
  output logic spi_do_o,
  // sleep pin and output comparators
  input wire logic device_sleep_pin_i,
  input wire logic reg1_good_i,
  input wire logic reg2_good_i,
  input wire logic reg3_good_i,
  input wire logic linear_reg_good_i,
  // regulator controls
  output logic reg1_on_o,
  output logic reg2_on_o,
  output logic reg3_on_o,
  output logic reg1_force_pwm_sel_o,
  output logic reg2_force_pwm_sel_o,
  output logic reg3_force_pwm_sel_o,
  output logic linear_reg_on_o,
  output logic osc_off_o,
  output logic power_good_o,
  // target voltages in millivolts
  output logic [11:0] reg1_target_mv_o,
  output logic [11:0] reg2_target_mv_o,
  output logic [11:0] reg3_target_mv_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers: bit 0 chip select, 1 clock, 2 data, 3 sleep, 4..7 good

  localparam logic [7:0] SYNC_RST = 8'h01;

  logic [7:0] in_raw;
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] sync3;
  logic [7:0] filt;
  logic [7:0] filt_d;

  assign in_raw = {linear_reg_good_i, reg3_good_i, reg2_good_i, reg1_good_i,
                   device_sleep_pin_i, spi_di_i, spi_clk_i, spi_cs_n_i};

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
      sync3 <= SYNC_RST;
      filt <= SYNC_RST;
      filt_d <= SYNC_RST;
    end else begin
      sync1 <= in_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= (sync3 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
      filt_d <= filt;
    end
  end

  logic cs_act;
  logic sck_rise;
  logic sck_fall;
  logic sleep_q;
  logic r1_good;
  logic r2_good;
  logic r3_good;
  logic lin_good;

  assign cs_act = ~filt[0];
  assign sck_rise = cs_act & filt[1] & ~filt_d[1];
  assign sck_fall = cs_act & ~filt[1] & filt_d[1];
  assign sleep_q = filt[3];
  assign r1_good = filt[4];
  assign r2_good = filt[5];
  assign r3_good = filt[6];
  assign lin_good = filt[7];

  ////////////////////////////////////////////////////////////////////////////////
  // serial frame decode

  logic [3:0] bit_cnt;
  logic [13:0] shift_in;
  logic [14:0] frame_next;
  logic wr_stb;
  logic hdr_done;
  logic rd_req;
  logic rd_act;
  logic [7:0] rd_shift;
  logic [7:0] rd_data;

  assign frame_next = {shift_in, filt[2]};
  assign wr_stb = sck_rise && bit_cnt == prc_pkg::FRAME_LAST && frame_next[14] && !frame_next[13];
  assign hdr_done = sck_rise && bit_cnt == prc_pkg::HDR_LAST;
  assign rd_req = hdr_done && frame_next[6] && frame_next[5];

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bit_cnt <= 4'h0;
      shift_in <= 14'h0000;
    end else if (!cs_act) begin
      bit_cnt <= 4'h0;
    end else if (sck_rise) begin
      shift_in <= frame_next[13:0];
      if (bit_cnt != 4'hf) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_act <= 1'b0;
      rd_shift <= 8'h00;
      spi_do_o <= 1'b0;
    end else if (!cs_act) begin
      rd_act <= 1'b0;
      spi_do_o <= 1'b0;
    end else if (rd_req) begin
      rd_act <= 1'b1;
      rd_shift <= rd_data;
    end else if (sck_fall && rd_act && bit_cnt > prc_pkg::HDR_LAST) begin
      spi_do_o <= rd_shift[7];
      rd_shift <= {rd_shift[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  logic [6:0] reg3_code;
  logic [5:0] reg1_code;
  logic [5:0] reg2_code;
  logic [6:0] reg3_sleep_code;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;

  assign wr_addr = frame_next[12:8];
  assign wr_data = frame_next[7:0];

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg3_code <= prc_pkg::RST_REG3_VOLT;
      reg1_code <= prc_pkg::RST_REG12_VOLT;
      reg2_code <= prc_pkg::RST_REG12_VOLT;
      reg3_sleep_code <= prc_pkg::RST_REG3_SLEEP;
    end else if (wr_stb) begin
      if (wr_addr == prc_pkg::ADDR_REG3_VOLT) begin
        reg3_code <= wr_data[6:0];
      end
      if (wr_addr == prc_pkg::ADDR_REG1_VOLT) begin
        reg1_code <= wr_data[5:0];
      end
      if (wr_addr == prc_pkg::ADDR_REG2_VOLT) begin
        reg2_code <= wr_data[5:0];
      end
      if (wr_addr == prc_pkg::ADDR_REG3_SLEEP) begin
        reg3_sleep_code <= wr_data[6:0]; // RULE_11
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg3_on_o <= prc_pkg::RST_REG_CTRL[prc_pkg::CTRL_REG3_ON];
      reg1_force_pwm_sel_o <= prc_pkg::RST_REG_CTRL[prc_pkg::CTRL_PWM1];
      reg2_force_pwm_sel_o <= prc_pkg::RST_REG_CTRL[prc_pkg::CTRL_PWM2];
      reg3_force_pwm_sel_o <= prc_pkg::RST_REG_CTRL[prc_pkg::CTRL_PWM3];
      reg1_on_o <= prc_pkg::RST_REG_CTRL[prc_pkg::CTRL_REG1_ON];
      reg2_on_o <= prc_pkg::RST_REG_CTRL[prc_pkg::CTRL_REG2_ON];
    end else if (wr_stb && wr_addr == prc_pkg::ADDR_REG_CTRL) begin
      reg3_on_o <= wr_data[prc_pkg::CTRL_REG3_ON]; // RULE_16
      reg1_force_pwm_sel_o <= wr_data[prc_pkg::CTRL_PWM1]; // RULE_01
      reg2_force_pwm_sel_o <= wr_data[prc_pkg::CTRL_PWM2]; // RULE_02
      reg3_force_pwm_sel_o <= wr_data[prc_pkg::CTRL_PWM3]; // RULE_03
      reg1_on_o <= wr_data[prc_pkg::CTRL_REG1_ON]; // RULE_04
      reg2_on_o <= wr_data[prc_pkg::CTRL_REG2_ON]; // RULE_05
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      linear_reg_on_o <= prc_pkg::RST_LIN_ON;
      osc_off_o <= prc_pkg::RST_OSC_OFF;
    end else if (wr_stb) begin
      if (wr_addr == prc_pkg::ADDR_LIN_CTRL) begin
        linear_reg_on_o <= wr_data[prc_pkg::LIN_ON]; // RULE_15
      end
      if (wr_addr == prc_pkg::ADDR_MISC_CTRL) begin
        osc_off_o <= wr_data[prc_pkg::MISC_OSC_OFF]; // RULE_14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data, reserved bits zero, status not writable

  always_comb begin
    rd_data = 8'h00;
    unique case (frame_next[4:0])
      prc_pkg::ADDR_REG3_VOLT: rd_data = {1'b0, reg3_code};
      prc_pkg::ADDR_REG1_VOLT: rd_data = {2'b00, reg1_code};
      prc_pkg::ADDR_REG2_VOLT: rd_data = {2'b00, reg2_code};
      prc_pkg::ADDR_REG3_SLEEP: rd_data = {1'b0, reg3_sleep_code}; // RULE_17
      prc_pkg::ADDR_REG_CTRL: begin
        rd_data[prc_pkg::CTRL_REG3_ON] = reg3_on_o;
        rd_data[prc_pkg::CTRL_PWM1] = reg1_force_pwm_sel_o;
        rd_data[prc_pkg::CTRL_PWM2] = reg2_force_pwm_sel_o;
        rd_data[prc_pkg::CTRL_PWM3] = reg3_force_pwm_sel_o;
        rd_data[prc_pkg::CTRL_REG1_ON] = reg1_on_o;
        rd_data[prc_pkg::CTRL_REG2_ON] = reg2_on_o;
      end
      prc_pkg::ADDR_LIN_CTRL: rd_data[prc_pkg::LIN_ON] = linear_reg_on_o;
      prc_pkg::ADDR_STATUS: begin
        rd_data[prc_pkg::ST_LIN_GOOD] = lin_good; // RULE_06
        rd_data[prc_pkg::ST_REG3_GOOD] = r3_good; // RULE_07
        rd_data[prc_pkg::ST_REG2_GOOD] = r2_good; // RULE_08
        rd_data[prc_pkg::ST_REG1_GOOD] = r1_good; // RULE_09
        rd_data[prc_pkg::ST_POWER_GOOD] = power_good_o; // RULE_17
      end
      prc_pkg::ADDR_MISC_CTRL: rd_data[prc_pkg::MISC_OSC_OFF] = osc_off_o;
      default: rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power good and target voltages

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      power_good_o <= 1'b0;
    end else begin
      power_good_o <= reg3_on_o && r3_good && (r2_good || !reg2_on_o) && // RULE_13
                      (r1_good || !reg1_on_o) && (lin_good || !linear_reg_on_o);
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg1_target_mv_o <= 12'h000;
      reg2_target_mv_o <= 12'h000;
      reg3_target_mv_o <= 12'h000;
    end else begin
      reg1_target_mv_o <= prc_pkg::prc_r12_mv(reg1_code); // RULE_10
      reg2_target_mv_o <= prc_pkg::prc_r12_mv(reg2_code); // RULE_10
      reg3_target_mv_o <= prc_pkg::prc_r3_mv(sleep_q ? reg3_sleep_code : reg3_code); // RULE_12
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  logic ctrl_wr;
  logic st_rd;
  assign ctrl_wr = wr_stb && wr_addr == prc_pkg::ADDR_REG_CTRL;
  assign st_rd = rd_req && frame_next[4:0] == prc_pkg::ADDR_STATUS;

  sequence s_ctrl_write;
    ctrl_wr;
  endsequence

  a_pwm1_write: assert property (s_ctrl_write |=> // RULE_01
                                 reg1_force_pwm_sel_o == $past(wr_data[4]))
    else $error("regulator one pwm select not loaded");
  a_pwm2_write: assert property (s_ctrl_write |=> // RULE_02
                                 reg2_force_pwm_sel_o == $past(wr_data[3]))
    else $error("regulator two pwm select not loaded");
  a_pwm3_hold: assert property (!ctrl_wr |=> $stable(reg3_force_pwm_sel_o)) // RULE_03
    else $error("regulator three pwm select changed without write");
  a_reg1_on_write: assert property (s_ctrl_write |=> reg1_on_o == $past(wr_data[1])) // RULE_04
    else $error("regulator one enable not loaded");
  a_reg2_on_write: assert property (s_ctrl_write |=> reg2_on_o == $past(wr_data[0])) // RULE_05
    else $error("regulator two enable not loaded");
  a_status_lin: assert property (st_rd |=> rd_shift[4] == $past(lin_good)) // RULE_06
    else $error("status linear good bit wrong");
  a_status_reg3: assert property (st_rd |=> rd_shift[3] == $past(r3_good)) // RULE_07
    else $error("status regulator three bit wrong");
  a_status_reg2: assert property (st_rd |=> rd_shift[2] == $past(r2_good)) // RULE_08
    else $error("status regulator two bit wrong");
  a_status_reg1: assert property (st_rd |=> rd_shift[1] == $past(r1_good)) // RULE_09
    else $error("status regulator one bit wrong");
  a_volt12_cap: assert property (reg1_code >= 6'h32 |=> reg1_target_mv_o == 12'd3400) // RULE_10
    else $error("regulator one voltage not capped");
  a_sleep_reserved: assert property (rd_req && // RULE_11
                                     frame_next[4:0] == prc_pkg::ADDR_REG3_SLEEP |=> !rd_shift[7])
    else $error("sleep register reserved bit set");
  a_reg3_sleep_map: assert property (sleep_q && $stable(sleep_q) |=> // RULE_12
    reg3_target_mv_o == 12'd865 + 12'd5 * {5'h00, $past(reg3_sleep_code)})
    else $error("regulator three sleep voltage wrong");
  a_pgood_off: assert property (!reg3_on_o ##1 !reg3_on_o |-> !power_good_o) // RULE_13
    else $error("power good high with regulator three off");
  a_osc_write: assert property (wr_stb && wr_addr == prc_pkg::ADDR_MISC_CTRL // RULE_14
                                |=> osc_off_o == $past(wr_data[1]))
    else $error("oscillator stop bit not loaded");
  a_lin_write: assert property (wr_stb && wr_addr == prc_pkg::ADDR_LIN_CTRL // RULE_15
                                |=> linear_reg_on_o == $past(wr_data[0]))
    else $error("linear regulator enable not loaded");
  a_reg3_on_write: assert property (s_ctrl_write |=> reg3_on_o == $past(wr_data[7])) // RULE_16
    else $error("regulator three enable not loaded");
  a_status_pgood: assert property (st_rd |=> // RULE_17
                                   rd_shift[0] == $past(power_good_o) && !rd_shift[7])
    else $error("status power good mirror wrong");

endmodule // prc_regs

// ---- test/prc_host.sv ----
// serial host model that drives the register port of the regulator bank
`timescale 1ns/100ps
module prc_host (
  // clock
  input wire logic clk_i,
  // serial lines
  output logic spi_cs_n_o,
  output logic spi_clk_o,
  output logic spi_di_o,
  input wire logic spi_do_i
);
  int half = 8;
  initial begin
    spi_cs_n_o = 1'b1;
    spi_clk_o = 1'b0;
    spi_di_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // data line wanders between frames so no stale bit is ever trusted
  always @(posedge clk_i) begin
    if (spi_cs_n_o) begin
      spi_di_o <= ~spi_di_o;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one frame msb first; nbits below 15 drops select early
  task automatic xfer(input logic [14:0] frame, input int nbits, output logic [7:0] rdata);
    rdata = 8'h00;
    @(posedge clk_i);
    spi_cs_n_o <= 1'b0;
    repeat (half) @(posedge clk_i);
    for (int i = 14; i > 14 - nbits; i--) begin
      spi_di_o <= frame[i];
      repeat (half) @(posedge clk_i);
      if (i < 8) begin
        rdata[i] = spi_do_i;
      end
      spi_clk_o <= 1'b1;
      repeat (half) @(posedge clk_i);
      spi_clk_o <= 1'b0;
    end
    repeat (half) @(posedge clk_i);
    spi_cs_n_o <= 1'b1;
    repeat (half) @(posedge clk_i);
  endtask
endmodule // prc_host

// ---- test/testbench.sv ----
// self-checking bench for the regulator control register bank
`timescale 1ns/100ps
module testbench;
  logic clk_i, sys_rst_i, cs_n, sck, di, do_w, slp, g1, g2, g3, gl, pg;
  logic r1, r2, r3, p1, p2, p3, lin, osc;
  logic [11:0] mv1, mv2, mv3, ctl;
  logic [7:0] v, cv, st;
  logic [7:0] tbl [8] = '{8'h00, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h80, 8'hff};
  logic [5:0] codes [6] = '{6'h00, 6'h01, 6'h31, 6'h32, 6'h33, 6'h3f};
  int n_fail = 0;
  int compares = 0;
  assign ctl = {4'h0, r3, p1, p2, p3, lin, osc, r1, r2};
  prc_regs uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi_cs_n_i(cs_n), .spi_clk_i(sck),
    .spi_di_i(di), .spi_do_o(do_w), .device_sleep_pin_i(slp), .reg1_good_i(g1),
    .reg2_good_i(g2), .reg3_good_i(g3), .linear_reg_good_i(gl), .reg1_on_o(r1),
    .reg2_on_o(r2), .reg3_on_o(r3), .reg1_force_pwm_sel_o(p1), .reg2_force_pwm_sel_o(p2),
    .reg3_force_pwm_sel_o(p3), .linear_reg_on_o(lin), .osc_off_o(osc), .power_good_o(pg),
    .reg1_target_mv_o(mv1), .reg2_target_mv_o(mv2), .reg3_target_mv_o(mv3));
  prc_host host (.clk_i(clk_i), .spi_cs_n_o(cs_n), .spi_clk_o(sck), .spi_di_o(di),
    .spi_do_i(do_w));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] nc;
    host.xfer({2'b10, a, d}, 15, nc);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] got;
    host.xfer({2'b11, a, 8'h00}, 15, got);
    chk_reg(got, exp);
  endtask
  function automatic logic [11:0] mv12(input logic [5:0] c);
    return (c >= 6'h32) ? 12'd3400 : 12'd900 + 12'd50 * {6'h00, c};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #5_000_000;
    n_fail++;
    results();
  end
  initial begin
    sys_rst_i = 1'b1;
    slp = 1'b0;
    {gl, g3, g2, g1} = 4'h0;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    // defaults
    rd_chk(5'h09, 8'h7f);
    rd_chk(5'h0a, 8'h83);
    rd_chk(5'h0b, 8'h01);
    rd_chk(5'h0e, 8'h00);
    chk_pin(ctl, 12'h08b);
    // each control bit alone, reserved bits dropped
    foreach (tbl[k]) begin
      wr(5'h0a, tbl[k]);
      cv = tbl[k];
      rd_chk(5'h0a, cv & 8'h9f);
      v = {cv[7], cv[4:2], 2'b10, cv[1:0]};
      chk_pin(ctl, {4'h0, v});
    end
    // status and power good over all comparator levels, enables varied
    for (int i = 0; i < 32; i++) begin
      if (i == 0 || i == 16) begin
        wr(5'h0a, (i == 0) ? 8'h83 : 8'h80);
      end
      @(posedge clk_i);
      {gl, g3, g2, g1} <= i[3:0];
      repeat (8) @(posedge clk_i);
      st = {3'b000, i[3:0], i[2] & (i[1] | i[4]) & (i[0] | i[4]) & i[3]};
      rd_chk(5'h0d, st);
      chk_pin({11'h000, pg}, {11'h000, st[0]});
    end
    wr(5'h0d, 8'h00);
    rd_chk(5'h0d, st);
    wr(5'h0a, 8'h03);
    repeat (8) @(posedge clk_i);
    chk_pin({11'h000, pg}, 12'h000);
    rd_chk(5'h0d, 8'h1e);
    rd_chk(5'h1f, 8'h00);
    // voltage codes for regulators one and two
    foreach (codes[k]) begin
      wr(5'h07, {2'b00, codes[k]});
      wr(5'h08, {2'b00, ~codes[k]});
      chk_pin(mv1, mv12(codes[k]));
      chk_pin(mv2, mv12(~codes[k]));
    end
    // regulator three active and sleep codes
    wr(5'h00, 8'h10);
    wr(5'h09, 8'h80);
    rd_chk(5'h09, 8'h00);
    chk_pin(mv3, 12'd945);
    @(posedge clk_i);
    slp <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk_pin(mv3, 12'd865);
    wr(5'h09, 8'hff);
    chk_pin(mv3, 12'd1500);
    slp <= 1'b0;
    // software sleep entry then wake in reverse, wake with a slow host
    wr(5'h0a, 8'h80);
    wr(5'h0b, 8'h00);
    wr(5'h0e, 8'h02);
    chk_pin(ctl, 12'h084);
    host.half = 20;
    wr(5'h0e, 8'h00);
    wr(5'h0b, 8'h01);
    wr(5'h0a, 8'h83);
    host.half = 8;
    chk_pin(ctl, 12'h08b);
    // short frame and frame without start bit change nothing
    host.xfer({2'b10, 5'h0a, 8'h00}, 10, v);
    host.xfer({2'b00, 5'h0a, 8'h00}, 15, v);
    rd_chk(5'h0a, 8'h83);
    // reset in mid-run restores defaults
    wr(5'h0a, 8'h1c);
    wr(5'h0b, 8'h00);
    wr(5'h09, 8'h00);
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk_pin(ctl, 12'h08b);
    chk_pin(mv1, 12'd1800);
    rd_chk(5'h09, 8'h7f);
    results();
  end
endmodule // testbench
